// *** frm_defines.svh ***
// Constants for the flash read-mode and drive-strength command logic
`ifndef FRM_DEFINES_SVH
`define FRM_DEFINES_SVH

// Bus command codes
`define FRM_CMD_READ_ARRAY   16'h00FF
`define FRM_CMD_READ_STATUS  16'h0070
`define FRM_CMD_READ_IDENT   16'h0090
`define FRM_CMD_READ_QUERY   16'h0098
`define FRM_CMD_CFG_SETUP    16'h0060
`define FRM_CMD_DRIVE_CONF   16'h0004
`define FRM_CMD_RBC_CONF     16'h0003

// Identification-space offsets from the partition base
`define FRM_ID_MAKER         8'h00
`define FRM_ID_PART          8'h01
`define FRM_ID_RBC           8'h05
`define FRM_ID_DRIVE         8'h06

// Register layout and reset values
`define FRM_DRIVE_RESET      16'h0004
`define FRM_DRIVE_CODE_MSB   2
`define FRM_DRIVE_CODE_LSB   0
`define FRM_DRIVE_CODE_MIN   3'h1
`define FRM_DRIVE_CODE_MAX   3'h6
`define FRM_RBC_RESET        16'h8000

`endif

// *** frm_host_model.sv ***
// Host-side model issuing bus writes and reads to the read-mode block
`timescale 1ns/100ps
module frm_host_model (
  // Clock
  input  wire logic             clk_sys,
  // Requests toward the device
  output frm_pkg::frm_wr_t      hostWr,
  output logic                  rdReq,
  output logic [2:0]            rdPart,
  output logic [15:0]           rdAddr,
  // Answer from the device
  input  wire frm_pkg::frm_rd_t rdOut
);
  // Idle bus at time zero
  initial begin
    hostWr = '0;
    rdReq  = 1'b0;
    rdPart = 3'h0;
    rdAddr = 16'h0000;
  end

  // One write, held across the rising edge that takes it
  task automatic wr(input logic [2:0] p, input logic [15:0] a,
                    input logic [15:0] d);
    @(negedge clk_sys);
    hostWr = '{valid: 1'b1, part: p, addr: a, data: d};
    @(negedge clk_sys);
    // Released lines flip so a stale value can never pass as live
    hostWr = '{valid: 1'b0, part: ~p, addr: ~a, data: ~d};
  endtask

  // Setup and confirm on consecutive edges, valid held between them
  task automatic wrPair(input logic [2:0] p, input logic [15:0] a,
                        input logic [15:0] d1, input logic [15:0] d2);
    @(negedge clk_sys);
    hostWr = '{valid: 1'b1, part: p, addr: a, data: d1};
    @(negedge clk_sys);
    hostWr = '{valid: 1'b1, part: p, addr: a, data: d2};
    @(negedge clk_sys);
    hostWr = '{valid: 1'b0, part: ~p, addr: ~a, data: ~d2};
  endtask

  // One read; the answer stands for one cycle after the taking edge
  task automatic rd(input logic [2:0] p, input logic [15:0] a,
                    output frm_pkg::frm_rd_t r);
    @(negedge clk_sys);
    rdReq  = 1'b1;
    rdPart = p;
    rdAddr = a;
    @(negedge clk_sys);
    rdReq  = 1'b0;
    rdPart = ~p;
    rdAddr = ~a;
    r      = rdOut;
  endtask
endmodule

// *** frm_pkg.sv ***
// Types for the flash read-mode and drive-strength command logic
package frm_pkg;

  // Per-partition read mode
  typedef enum logic [1:0] {
    FRM_ARRAY  = 2'h0,
    FRM_STATUS = 2'h1,
    FRM_IDENT  = 2'h3,
    FRM_QUERY  = 2'h2
  } frm_mode_t;

  // Command interpreter sequence state
  typedef enum logic [1:0] {
    FRM_IDLE      = 2'h0,
    FRM_DRV_WAIT  = 2'h1,
    FRM_RBC_WAIT  = 2'h3
  } frm_seq_t;

  // One bus write from the host
  typedef struct packed {
    logic        valid;
    logic [2:0]  part;
    logic [15:0] addr;
    logic [15:0] data;
  } frm_wr_t;

  // Read answer
  typedef struct packed {
    logic [15:0] data;
    logic        valid;
  } frm_rd_t;

endpackage

// *** frm_read_mode.sv ***
// Per-partition read-mode command logic with drive-strength register
`timescale 1ns/100ps
`include "frm_defines.svh"

module frm_read_mode #(
  parameter int NPART = 8,
  parameter logic [15:0] MAKER_CODE = 16'h00A5, // Arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h5A5A  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // Host write port
  input  wire frm_pkg::frm_wr_t     hostWr,
  // Host read request
  input  wire logic                 rdReq,
  input  wire logic [2:0]           rdPart,
  input  wire logic [15:0]          rdAddr,
  // Data sources from the rest of the device
  input  wire logic [15:0]          arrayData,
  input  wire logic [15:0]          statusData,
  input  wire logic [15:0]          queryData,
  input  wire logic [15:0]          identAuxData,
  input  wire logic [NPART-1:0]     partBusy,
  input  wire logic [NPART-1:0]     opStart,
  input  wire logic [NPART-1:0]     lockSetup,
  input  wire logic [NPART-1:0]     opResume,
  input  wire logic                 protectSupplyLow,
  // Read answer and configuration outputs
  output frm_pkg::frm_rd_t          rdOut,
  output logic [2:0]                driveCode,
  output logic [15:0]               readBehaviourCfg
);

  // Whole module state
  typedef struct packed {
    frm_pkg::frm_mode_t [NPART-1:0] mode;
    frm_pkg::frm_seq_t              seq;
    logic [15:0]                    driveCfg;
    logic [15:0]                    rbcCfg;
    frm_pkg::frm_rd_t               rd;
  } frm_state_t;

  frm_state_t st_reg;
  frm_state_t st_next;

  // Ident-space lookup, used by every ident-mode read
  function automatic logic [15:0] identWord(
    input logic [15:0] off,
    input logic [15:0] drv,
    input logic [15:0] rbc,
    input logic [15:0] aux
  );
    logic [15:0] r;
    r = aux; // Lock, OTP and other device info from outside
    case (off[7:0])
      `FRM_ID_MAKER: r = MAKER_CODE;
      `FRM_ID_PART:  r = PART_CODE;
      `FRM_ID_RBC:   r = rbc;
      `FRM_ID_DRIVE: r = drv;
      default:       r = aux;
    endcase
    if (off[15:8] != 8'h00) begin
      r = aux;
    end
    return r;
  endfunction

  // Next-state logic
  always_comb begin
    logic [15:0] d;
    logic [2:0]  p;
    d = hostWr.data;
    p = hostWr.part;
    st_next = st_reg;
    st_next.rd.valid = 1'b0;
    // Engine events move partitions to status mode first
    for (int i = 0; i < NPART; i++) begin
      if (opStart[i] || lockSetup[i] || opResume[i]) begin
        st_next.mode[i] = frm_pkg::FRM_STATUS;
      end
    end
    // Host command; protect supply deliberately not consulted
    if (hostWr.valid) begin
      case (st_reg.seq)
        frm_pkg::FRM_DRV_WAIT, frm_pkg::FRM_RBC_WAIT: begin
          st_next.seq = frm_pkg::FRM_IDLE;
          // One setup code serves both registers; confirm picks one
          if (d == `FRM_CMD_DRIVE_CONF) begin
            st_next.driveCfg = hostWr.addr;
            st_next.mode[p] = frm_pkg::FRM_ARRAY;
          end else if (d == `FRM_CMD_RBC_CONF) begin
            st_next.rbcCfg = hostWr.addr;
            st_next.mode[p] = frm_pkg::FRM_ARRAY;
          end else begin
            // Bad confirm: abandon, report status
            st_next.mode[p] = frm_pkg::FRM_STATUS;
          end
        end
        default: begin
          // Only the addressed partition changes
          case (d)
            `FRM_CMD_READ_ARRAY:  st_next.mode[p] = frm_pkg::FRM_ARRAY;
            `FRM_CMD_READ_STATUS: st_next.mode[p] = frm_pkg::FRM_STATUS;
            `FRM_CMD_READ_IDENT:  st_next.mode[p] = frm_pkg::FRM_IDENT;
            `FRM_CMD_READ_QUERY:  st_next.mode[p] = frm_pkg::FRM_QUERY;
            `FRM_CMD_CFG_SETUP: begin
              st_next.mode[p] = frm_pkg::FRM_STATUS;
              // Confirm code picks the target register
              st_next.seq = frm_pkg::FRM_DRV_WAIT;
            end
            default: st_next.seq = frm_pkg::FRM_IDLE;
          endcase
        end
      endcase
    end
    // Read data source follows the partition mode
    if (rdReq) begin
      st_next.rd.valid = 1'b1;
      case (st_reg.mode[rdPart])
        frm_pkg::FRM_ARRAY: begin
          // Busy partition: data not valid until operation ends
          st_next.rd.data  = arrayData;
          st_next.rd.valid = !partBusy[rdPart];
        end
        frm_pkg::FRM_STATUS: st_next.rd.data = statusData;
        frm_pkg::FRM_IDENT: begin
          st_next.rd.data  = identWord(rdAddr, st_reg.driveCfg,
                                       st_reg.rbcCfg, identAuxData);
          st_next.rd.valid = !partBusy[rdPart];
        end
        frm_pkg::FRM_QUERY: begin
          st_next.rd.data  = queryData;
          st_next.rd.valid = !partBusy[rdPart];
        end
        default: st_next.rd.data = 16'h0000;
      endcase
    end
  end

  // State register, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < NPART; i++) begin
        st_reg.mode[i] <= frm_pkg::FRM_ARRAY;
      end
      st_reg.seq      <= frm_pkg::FRM_IDLE;
      st_reg.driveCfg <= `FRM_DRIVE_RESET;
      st_reg.rbcCfg   <= `FRM_RBC_RESET;
      st_reg.rd       <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state flops
  assign rdOut            = st_reg.rd;
  // Reserved codes are kept as written; the pad logic must tolerate them
  assign driveCode        =
    st_reg.driveCfg[`FRM_DRIVE_CODE_MSB:`FRM_DRIVE_CODE_LSB];
  assign readBehaviourCfg = st_reg.rbcCfg;

  // Assertions share one clock; reset mutes them while it is held
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Setup write seen while no sequence is pending
  sequence s_setup;
    hostWr.valid && hostWr.data == `FRM_CMD_CFG_SETUP &&
    st_reg.seq == frm_pkg::FRM_IDLE;
  endsequence

  // Confirm for the drive register
  sequence s_confirm;
    hostWr.valid && hostWr.data == `FRM_CMD_DRIVE_CONF;
  endsequence

  // Confirm for the read-behaviour register
  sequence s_rbc_confirm;
    hostWr.valid && hostWr.data == `FRM_CMD_RBC_CONF;
  endsequence

  // Any other write after setup abandons the sequence
  sequence s_bad_confirm;
    hostWr.valid && hostWr.data != `FRM_CMD_DRIVE_CONF &&
    hostWr.data != `FRM_CMD_RBC_CONF;
  endsequence

  // No engine event, so a host command acts alone
  sequence s_quiet;
    opStart == '0 && lockSetup == '0 && opResume == '0;
  endsequence

  // Idle-state host write; engine events are left to s_quiet
  sequence s_mode_cmd;
    hostWr.valid && st_reg.seq == frm_pkg::FRM_IDLE;
  endsequence

  // Reset defaults, checked on the first edge after release
  a_reset_array_mode: assert property (
    $past(rst) |-> st_reg.mode[0] == frm_pkg::FRM_ARRAY)
    else $error("partition not in array mode after reset");

  a_reset_all_array: assert property (
    $past(rst) |-> st_reg.mode == '0)
    else $error("some partition not in array mode after reset");

  a_reset_drive_value: assert property (
    $past(rst) |-> driveCode == 3'h4 && st_reg.driveCfg == `FRM_DRIVE_RESET)
    else $error("drive register not 0004h after reset");

  a_reset_rbc_value: assert property (
    $past(rst) |-> readBehaviourCfg == `FRM_RBC_RESET)
    else $error("read-behaviour register not at reset value");

  a_reset_read_idle: assert property (
    $past(rst) |-> !rdOut.valid)
    else $error("read answer valid straight after reset");

  // Register programming sequence
  a_setup_status: assert property (
    s_setup and (opResume == '0) |=>
      st_reg.mode[$past(hostWr.part)] == frm_pkg::FRM_STATUS)
    else $error("setup did not select status mode");

  a_confirm_loads: assert property (
    s_setup ##1 s_confirm |=> st_reg.driveCfg == $past(hostWr.addr))
    else $error("drive register not loaded on confirm");

  a_confirm_array: assert property (
    s_setup ##1 (s_confirm and s_quiet) |=>
      st_reg.mode[$past(hostWr.part)] == frm_pkg::FRM_ARRAY)
    else $error("confirm did not select array mode");

  a_rbc_confirm_loads: assert property (
    s_setup ##1 s_rbc_confirm |=> readBehaviourCfg == $past(hostWr.addr))
    else $error("read-behaviour register not loaded on confirm");

  a_rbc_confirm_array: assert property (
    s_setup ##1 (s_rbc_confirm and s_quiet) |=>
      st_reg.mode[$past(hostWr.part)] == frm_pkg::FRM_ARRAY)
    else $error("read-behaviour confirm did not select array mode");

  a_bad_confirm_status: assert property (
    s_setup ##1 s_bad_confirm |=>
      st_reg.mode[$past(hostWr.part)] == frm_pkg::FRM_STATUS &&
      st_reg.seq == frm_pkg::FRM_IDLE)
    else $error("refused confirm did not fall back to status");

  a_drive_held: assert property (
    !hostWr.valid |=> $stable(st_reg.driveCfg))
    else $error("drive register changed without a write");

  // Single-write read-mode commands
  a_ident_cmd: assert property (
    (s_mode_cmd and s_quiet) ##0 hostWr.data == `FRM_CMD_READ_IDENT |=>
      st_reg.mode[$past(hostWr.part)] == frm_pkg::FRM_IDENT)
    else $error("ident command ignored");

  a_array_cmd: assert property (
    (s_mode_cmd and s_quiet) ##0 hostWr.data == `FRM_CMD_READ_ARRAY |=>
      st_reg.mode[$past(hostWr.part)] == frm_pkg::FRM_ARRAY)
    else $error("array command ignored");

  a_status_cmd: assert property (
    (s_mode_cmd and s_quiet) ##0 hostWr.data == `FRM_CMD_READ_STATUS |=>
      st_reg.mode[$past(hostWr.part)] == frm_pkg::FRM_STATUS)
    else $error("status command ignored");

  a_query_cmd: assert property (
    (s_mode_cmd and s_quiet) ##0 hostWr.data == `FRM_CMD_READ_QUERY |=>
      st_reg.mode[$past(hostWr.part)] == frm_pkg::FRM_QUERY)
    else $error("query command ignored");

  a_other_part_kept: assert property (
    hostWr.valid && hostWr.part != 3'h0 && !opStart[0] && !lockSetup[0] &&
    !opResume[0] |=> $stable(st_reg.mode[0]))
    else $error("unaddressed partition changed mode");

  // Engine events force status mode
  a_event_status: assert property (
    opStart[1] && !(hostWr.valid && hostWr.part == 3'h1) |=>
      st_reg.mode[1] == frm_pkg::FRM_STATUS)
    else $error("operation start did not select status mode");

  a_ident_start: assert property (
    opStart[2] && !(hostWr.valid && hostWr.part == 3'h2) |=>
      st_reg.mode[2] == frm_pkg::FRM_STATUS)
    else $error("start in ident partition did not select status");

  a_lock_status: assert property (
    lockSetup[4] && !(hostWr.valid && hostWr.part == 3'h4) |=>
      st_reg.mode[4] == frm_pkg::FRM_STATUS)
    else $error("lock setup did not select status mode");

  a_resume_status: assert property (
    opResume[5] && !(hostWr.valid && hostWr.part == 3'h5) |=>
      st_reg.mode[5] == frm_pkg::FRM_STATUS)
    else $error("resume did not select status mode");

  // Read answers by mode
  a_ident_drive_read: assert property (
    rdReq && st_reg.mode[rdPart] == frm_pkg::FRM_IDENT &&
    rdAddr == 16'h0006 && !partBusy[rdPart] |=>
      rdOut.valid && rdOut.data == $past(st_reg.driveCfg))
    else $error("drive register not returned at offset 06h");

  a_ident_rbc_read: assert property (
    rdReq && st_reg.mode[rdPart] == frm_pkg::FRM_IDENT &&
    rdAddr == 16'h0005 && !partBusy[rdPart] |=>
      rdOut.valid && rdOut.data == $past(st_reg.rbcCfg))
    else $error("read-behaviour register not returned at offset 05h");

  a_ident_maker_read: assert property (
    rdReq && st_reg.mode[rdPart] == frm_pkg::FRM_IDENT &&
    rdAddr == 16'h0000 && !partBusy[rdPart] |=>
      rdOut.valid && rdOut.data == MAKER_CODE)
    else $error("maker code not returned at offset 00h");

  a_array_read: assert property (
    rdReq && st_reg.mode[rdPart] == frm_pkg::FRM_ARRAY &&
    !partBusy[rdPart] |=> rdOut.valid && rdOut.data == $past(arrayData))
    else $error("array read returned wrong data");

  a_status_read: assert property (
    rdReq && st_reg.mode[rdPart] == frm_pkg::FRM_STATUS |=>
      rdOut.valid && rdOut.data == $past(statusData))
    else $error("status read returned wrong data");

  a_read_pulse: assert property (
    !rdReq |=> !rdOut.valid)
    else $error("read answer valid without a request");

  a_busy_invalid: assert property (
    rdReq && partBusy[rdPart] && st_reg.mode[rdPart] == frm_pkg::FRM_ARRAY
    |=> !rdOut.valid)
    else $error("busy partition array read marked valid");

endmodule

// *** tb.sv ***
// Self-checking bench for the read-mode and drive-strength logic
`timescale 1ns/100ps
`include "frm_defines.svh"
module tb;
  localparam logic [15:0] MAKER = 16'h00C3; // Arbitrary value
  localparam logic [15:0] PARTC = 16'h3C3C; // Arbitrary value
  localparam logic [15:0] CMDS [4] = '{`FRM_CMD_READ_ARRAY,
    `FRM_CMD_READ_STATUS, `FRM_CMD_READ_IDENT, `FRM_CMD_READ_QUERY};
  localparam frm_pkg::frm_mode_t MODES [4] = '{frm_pkg::FRM_ARRAY,
    frm_pkg::FRM_STATUS, frm_pkg::FRM_IDENT, frm_pkg::FRM_QUERY};
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic [15:0]        arrayData = 16'h0000;
  logic [15:0]        statusData = 16'h0000;
  logic [15:0]        queryData = 16'h0000;
  logic [15:0]        identAuxData = 16'h0000;
  logic [7:0]         partBusy = 8'h00;
  logic [7:0]         opStart = 8'h00;
  logic [7:0]         lockSetup = 8'h00;
  logic [7:0]         opResume = 8'h00;
  logic               protectSupplyLow = 1'b0;
  frm_pkg::frm_wr_t   hostWr;
  logic               rdReq;
  logic [2:0]         rdPart;
  logic [15:0]        rdAddr;
  frm_pkg::frm_rd_t   rdOut;
  frm_pkg::frm_rd_t   r;
  logic [2:0]         driveCode;
  logic [15:0]        readBehaviourCfg;
  logic [2:0]         p;
  logic [15:0]        v;
  logic [15:0]        drvExp;
  logic [15:0]        rbcExp;
  frm_pkg::frm_mode_t mode [8];
  int                 k;
  int                 errors = 0;
  int                 checks_done = 0;

  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;

  frm_read_mode #(.NPART(8), .MAKER_CODE(MAKER), .PART_CODE(PARTC))
  i_frm_read_mode (.clk_sys(clk_sys), .rst(rst), .hostWr(hostWr),
    .rdReq(rdReq), .rdPart(rdPart), .rdAddr(rdAddr),
    .arrayData(arrayData), .statusData(statusData), .queryData(queryData),
    .identAuxData(identAuxData), .partBusy(partBusy), .opStart(opStart),
    .lockSetup(lockSetup), .opResume(opResume),
    .protectSupplyLow(protectSupplyLow), .rdOut(rdOut),
    .driveCode(driveCode), .readBehaviourCfg(readBehaviourCfg));

  frm_host_model i_frm_host_model (.clk_sys(clk_sys), .hostWr(hostWr),
    .rdReq(rdReq), .rdPart(rdPart), .rdAddr(rdAddr), .rdOut(rdOut));

  // Expected read data from the modelled mode of a partition
  function automatic logic [15:0] expRd(input frm_pkg::frm_mode_t m,
                                        input logic [15:0] a);
    case (m)
      frm_pkg::FRM_ARRAY:  return arrayData;
      frm_pkg::FRM_STATUS: return statusData;
      frm_pkg::FRM_QUERY:  return queryData;
      default: case (a)
        16'h0000: return MAKER;
        16'h0001: return PARTC;
        16'h0005: return rbcExp;
        16'h0006: return drvExp;
        default:  return identAuxData;
      endcase
    endcase
  endfunction

  task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  // Fresh source data each read, so a wrong source cannot match
  task automatic doRd(input logic [2:0] pp, input logic [15:0] a);
    arrayData = 16'($urandom);
    statusData = 16'($urandom);
    queryData = 16'($urandom);
    identAuxData = 16'($urandom);
    i_frm_host_model.rd(pp, a, r);
    chkVal({15'h0000, r.valid}, 16'h0001);
    chkVal(r.data, expRd(mode[pp], a));
  endtask

  task automatic cmd(input logic [2:0] pp, input int c);
    i_frm_host_model.wr(pp, 16'($urandom), CMDS[c]);
    mode[pp] = MODES[c];
  endtask

  // Engine event pulse: 0 start, 1 lock setup, 2 resume
  task automatic ev(input int e, input logic [2:0] pp);
    @(negedge clk_sys);
    opStart[pp] = (e == 0);
    lockSetup[pp] = (e == 1);
    opResume[pp] = (e == 2);
    @(negedge clk_sys);
    opStart = 8'h00;
    lockSetup = 8'h00;
    opResume = 8'h00;
    mode[pp] = frm_pkg::FRM_STATUS;
  endtask

  task automatic doRst();
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    drvExp = `FRM_DRIVE_RESET;
    rbcExp = `FRM_RBC_RESET;
    foreach (mode[i]) mode[i] = frm_pkg::FRM_ARRAY;
  endtask

  // Defaults after any reset, seen through ident space
  task automatic chkDef();
    chkVal({13'h0000, driveCode}, 16'h0004);
    chkVal(readBehaviourCfg, rbcExp);
    for (int i = 0; i < 8; i++) doRd(3'(i), 16'h0000);
    cmd(3'h3, 2);
    doRd(3'h3, 16'h0006);
    doRd(3'h3, 16'h0005);
    doRd(3'h3, 16'h0000);
    doRd(3'h3, 16'h0001);
    cmd(3'h3, 0);
  endtask

  task automatic end_sim();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog far beyond the roughly 500 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    end_sim();
  end

  initial begin
    void'($urandom(32'hDDFD));
    doRst();
    chkDef();
    for (int n = 0; n < 60; n++) begin
      protectSupplyLow = 1'($urandom);
      k = $urandom_range(3);
      cmd(3'($urandom), k);
      doRd(3'($urandom), 16'($urandom_range(7)));
    end
    for (int c = 1; c <= 6; c++) begin
      p = 3'($urandom);
      v = {13'h0000, 3'(c)};
      protectSupplyLow = 1'b1;
      i_frm_host_model.wr(p, v, `FRM_CMD_CFG_SETUP);
      mode[p] = frm_pkg::FRM_STATUS;
      doRd(p, 16'h0000);
      i_frm_host_model.wr(p, v, `FRM_CMD_DRIVE_CONF);
      mode[p] = frm_pkg::FRM_ARRAY;
      drvExp = v;
      doRd(p, 16'h0000);
      chkVal({13'h0000, driveCode}, v);
      cmd(p, 2);
      doRd(p, 16'h0006);
    end
    // Back-to-back setup and confirm, then a refused confirm
    for (int n = 0; n < 4; n++) begin
      p = 3'($urandom);
      v = {13'h0000, 3'($urandom_range(6, 1))};
      i_frm_host_model.wrPair(p, v, `FRM_CMD_CFG_SETUP,
                              `FRM_CMD_DRIVE_CONF);
      drvExp = v;
      chkVal({13'h0000, driveCode}, v);
      v = 16'($urandom);
      i_frm_host_model.wrPair(p, v, `FRM_CMD_CFG_SETUP,
                              `FRM_CMD_RBC_CONF);
      rbcExp = v;
      mode[p] = frm_pkg::FRM_ARRAY;
      chkVal(readBehaviourCfg, v);
      doRd(p, 16'h0000);
      cmd(p, 2);
      doRd(p, 16'h0005);
      doRd(p, 16'h0006);
      i_frm_host_model.wrPair(p, 16'($urandom), `FRM_CMD_CFG_SETUP,
                              `FRM_CMD_READ_ARRAY);
      mode[p] = frm_pkg::FRM_STATUS;
      doRd(p, 16'h0000);
    end
    cmd(3'h1, 0);
    ev(0, 3'h1);
    doRd(3'h1, 16'h0000);
    cmd(3'h2, 2);
    ev(0, 3'h2);
    doRd(3'h2, 16'h0000);
    cmd(3'h4, 0);
    ev(1, 3'h4);
    doRd(3'h4, 16'h0000);
    cmd(3'h5, 0);
    ev(2, 3'h5);
    doRd(3'h5, 16'h0000);
    partBusy[6] = 1'b1;
    cmd(3'h6, 0);
    i_frm_host_model.rd(3'h6, 16'h0000, r);
    chkVal({15'h0000, r.valid}, 16'h0000);
    partBusy = 8'h00;
    doRst();
    chkDef();
    end_sim();
  end
endmodule
